// ==== logic/bmcphy_pkg.sv ====
// bmcphy_pkg: timing, reset values and state codes of the cc line phy
// assumes a single 25 MHz reference clock for every user of the package
package bmcphy_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS             = 40;
    localparam int unsigned UI_TIME_NS                = 3333;  // nominal bit time
    localparam int unsigned TRANSITION_WINDOW_TIME_NS = 20000;
    localparam int unsigned HALF_UI_CYC  = UI_TIME_NS / (2 * CLK_PERIOD_NS);
    localparam int unsigned EDGE_THR_CYC = (3 * UI_TIME_NS) / (4 * CLK_PERIOD_NS);
    localparam int unsigned STALE_CYC    = (2 * UI_TIME_NS) / CLK_PERIOD_NS;
    localparam int unsigned WINDOW_CYC   = TRANSITION_WINDOW_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned MIN_TRANSITION_COUNT = 3;

    // ------------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------------
    localparam int unsigned CNT_W      = 10;
    localparam logic        LINE_RST   = 1'b0;
    localparam logic        SEL_RST    = 1'b0;  // cc1
    localparam logic [2:0]  TCOUNT_RST = 3'h0;

    typedef logic [CNT_W-1:0] bmcphy_cnt_t;

    typedef enum logic [3:0] {
        TX_IDLE = 4'h1,
        TX_LEAD = 4'h2,
        TX_BITS = 4'h4,
        TX_TAIL = 4'h8
    } bmcphy_tx_st_t;

endpackage

// ==== logic/bmcphy_buf2.sv ====
// bmcphy_buf2: small valid/ready buffer, two entries by default
// assumes both sides on ref_clk; in_ready and out_valid come from flops
module bmcphy_buf2 #(
    parameter int unsigned W     = 2,
    parameter int unsigned DEPTH = 2
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    // filling side
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    // draining side
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    typedef logic [AW:0] bmcphy_fill_t;

    logic [W-1:0]  mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    bmcphy_fill_t  fill_q;
    bmcphy_fill_t  fill_d;
    wire           push = in_valid && in_ready;
    wire           pop  = out_valid && out_ready;

    // fill level next value
    assign fill_d   = fill_q + bmcphy_fill_t'(push) - bmcphy_fill_t'(pop);
    assign out_data = mem_q[rp_q];

    // pointers and flags
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wp_q      <= '0;
            rp_q      <= '0;
            fill_q    <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
            end
            fill_q    <= fill_d;
            in_ready  <= fill_d != bmcphy_fill_t'(DEPTH);
            out_valid <= fill_d != '0;
        end
    end

    // storage
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end

endmodule

// ==== logic/bmcphy_line_phy.sv ====
// bmcphy_line_phy: biphase mark coder, decoder and squelch for one cc pair
// assumes cc pins arrive asynchronously and attach/orientation come from ref_clk logic
module bmcphy_line_phy #(
    parameter int unsigned HALF_UI   = bmcphy_pkg::HALF_UI_CYC,
    parameter int unsigned EDGE_THR  = bmcphy_pkg::EDGE_THR_CYC,
    parameter int unsigned STALE     = bmcphy_pkg::STALE_CYC,
    parameter int unsigned WINDOW    = bmcphy_pkg::WINDOW_CYC,
    parameter int unsigned MIN_TRANS = bmcphy_pkg::MIN_TRANSITION_COUNT
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    // attach state and orientation
    input  wire logic attached,
    input  wire logic orient_flip,
    // transmit bit stream
    input  wire logic tx_bit,
    input  wire logic tx_last,
    input  wire logic tx_valid,
    output logic      tx_ready,
    output logic      tx_busy,
    // receive bit stream and squelch
    output logic      rx_bit,
    output logic      rx_bit_valid,
    output logic      rx_active,
    // cc pins
    input  wire logic cc1_in,
    output logic      cc1_out,
    output logic      cc1_oe,
    input  wire logic cc2_in,
    output logic      cc2_out,
    output logic      cc2_oe
);
    typedef bmcphy_pkg::bmcphy_cnt_t bmcphy_cnt_t;
    // ------------------------------------------------------------------
    // orientation latch
    // ------------------------------------------------------------------
    logic att_q;
    logic sel_q;  // 0 selects cc1
    // orientation taken only when the connection starts
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            att_q <= 1'b0;
            sel_q <= bmcphy_pkg::SEL_RST;
        end else begin
            att_q <= attached;
            if (attached && !att_q) begin
                sel_q <= orient_flip;
            end
        end
    end

    // ------------------------------------------------------------------
    // transmit buffer and encoder
    // ------------------------------------------------------------------
    logic [1:0]                f_data;
    logic                      f_valid;
    logic                      f_take;
    bmcphy_pkg::bmcphy_tx_st_t st_q;
    bmcphy_pkg::bmcphy_tx_st_t st_d;
    bmcphy_cnt_t               hc_q;
    logic                      phase_q;
    logic                      phase_d;
    logic                      line_q;
    logic                      line_d;
    logic                      cur_bit_q;
    logic                      cur_last_q;
    logic                      oe1_q;
    logic                      oe2_q;
    bmcphy_buf2 #(.W(2), .DEPTH(2)) u_txbuf (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .in_data   ({tx_last, tx_bit}),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .out_data  (f_data),
        .out_valid (f_valid),
        .out_ready (f_take)
    );
    // half bit timing and next bit selection
    wire  hc_wrap  = hc_q == bmcphy_cnt_t'(HALF_UI - 1);
    wire  boundary = (st_q == bmcphy_pkg::TX_BITS) && hc_wrap && phase_q;
    wire  mid      = (st_q == bmcphy_pkg::TX_BITS) && hc_wrap && !phase_q;
    wire  cont     = boundary && !cur_last_q && f_valid;
    wire  go_tail  = boundary && !cont;
    wire  lead_end = (st_q == bmcphy_pkg::TX_LEAD) && hc_wrap;
    wire  start    = (st_q == bmcphy_pkg::TX_IDLE) && att_q && f_valid;
    wire  drive_d  = (st_d != bmcphy_pkg::TX_IDLE);
    assign f_take  = lead_end || cont;
    // encoder next state and line level
    always_comb begin
        st_d    = st_q;
        line_d  = line_q;
        phase_d = phase_q;
        unique case (st_q)
            bmcphy_pkg::TX_IDLE: begin
                if (start) begin
                    st_d   = bmcphy_pkg::TX_LEAD;
                    line_d = 1'b0;
                end
            end
            bmcphy_pkg::TX_LEAD: begin
                if (hc_wrap) begin
                    st_d    = bmcphy_pkg::TX_BITS;
                    line_d  = !line_q;
                    phase_d = 1'b0;
                end
            end
            bmcphy_pkg::TX_BITS: begin
                if (mid) begin
                    line_d  = line_q ^ cur_bit_q;
                    phase_d = 1'b1;
                end else if (cont) begin
                    line_d  = !line_q;
                    phase_d = 1'b0;
                end else if (go_tail) begin
                    st_d   = bmcphy_pkg::TX_TAIL;
                    line_d = !line_q;
                end
            end
            bmcphy_pkg::TX_TAIL: begin
                if (hc_wrap) begin
                    st_d = bmcphy_pkg::TX_IDLE;
                end
            end
        endcase
        if (!att_q) begin
            st_d = bmcphy_pkg::TX_IDLE;
        end
    end
    // encoder registers and pin drive
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q       <= bmcphy_pkg::TX_IDLE;
            hc_q       <= '0;
            phase_q    <= 1'b0;
            line_q     <= bmcphy_pkg::LINE_RST;
            cur_bit_q  <= 1'b0;
            cur_last_q <= 1'b0;
            oe1_q      <= 1'b0;
            oe2_q      <= 1'b0;
            tx_busy    <= 1'b0;
        end else begin
            st_q    <= st_d;
            hc_q    <= (st_d != st_q || hc_wrap) ? '0 : hc_q + 1'b1;
            phase_q <= phase_d;
            line_q  <= line_d;
            if (f_take) begin
                cur_bit_q  <= f_data[0];
                cur_last_q <= f_data[1];
            end
            oe1_q   <= drive_d && !sel_q;
            oe2_q   <= drive_d && sel_q;
            tx_busy <= drive_d;
        end
    end
    assign cc1_out = line_q;
    assign cc2_out = line_q;
    assign cc1_oe  = oe1_q;
    assign cc2_oe  = oe2_q;
    // ------------------------------------------------------------------
    // receive synchroniser and decoder
    // ------------------------------------------------------------------
    logic        cc1_m_q;
    logic        cc1_s_q;
    logic        cc2_m_q;
    logic        cc2_s_q;
    logic        prev_q;
    logic        half_q;
    bmcphy_cnt_t ec_q;
    wire         rx_line  = sel_q ? cc2_s_q : cc1_s_q;
    wire         edge_det = rx_line ^ prev_q;
    wire         stale    = ec_q >= bmcphy_cnt_t'(STALE);
    wire         long_gap = ec_q >= bmcphy_cnt_t'(EDGE_THR);

    // two stage pin synchronisers, reset to the released line level
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cc1_m_q <= 1'b1;  // no false edge after reset
            cc1_s_q <= 1'b1;
            cc2_m_q <= 1'b1;
            cc2_s_q <= 1'b1;
        end else begin
            cc1_m_q <= cc1_in;
            cc1_s_q <= cc1_m_q;
            cc2_m_q <= cc2_in;
            cc2_s_q <= cc2_m_q;
        end
    end
    // edge spacing classifier
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_q       <= 1'b1;
            half_q       <= 1'b0;
            ec_q         <= '0;
            rx_bit       <= 1'b0;
            rx_bit_valid <= 1'b0;
        end else begin
            prev_q       <= rx_line;
            rx_bit_valid <= 1'b0;
            if (!edge_det) begin
                ec_q <= stale ? ec_q : ec_q + 1'b1;
            end else begin
                ec_q <= '0;
                if (stale) begin
                    half_q <= 1'b0;
                end else if (long_gap) begin
                    half_q       <= 1'b0;
                    rx_bit       <= 1'b0;
                    rx_bit_valid <= 1'b1;
                end else if (half_q) begin
                    half_q       <= 1'b0;
                    rx_bit       <= 1'b1;
                    rx_bit_valid <= 1'b1;
                end else begin
                    half_q <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // squelch
    // ------------------------------------------------------------------
    bmcphy_cnt_t wc_q;
    logic  [2:0] tc_q;
    wire         w_end = wc_q == bmcphy_cnt_t'(WINDOW - 1);
    wire   [2:0] tc_nx = tc_q + 3'(edge_det);
    wire         hit   = tc_nx >= 3'(MIN_TRANS);
    // transition count per window, held at the minimum once reached
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wc_q      <= '0;
            tc_q      <= bmcphy_pkg::TCOUNT_RST;
            rx_active <= 1'b0;
        end else begin
            wc_q <= w_end ? '0 : wc_q + 1'b1;
            tc_q <= w_end ? 3'h0 : (hit ? 3'(MIN_TRANS) : tc_nx);
            if (hit) begin
                rx_active <= 1'b1;
            end else if (w_end) begin
                rx_active <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    bmcphy_cnt_t run_q;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            run_q <= '0;
        end else begin
            run_q <= (line_d != line_q || !drive_d) ? '0 : run_q + 1'b1;
        end
    end
    chk_one_driver: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !(cc1_oe && cc2_oe)) else $error("both cc drivers on");
    chk_idle_release: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (st_q == bmcphy_pkg::TX_IDLE) |-> !cc1_oe && !cc2_oe) else $error("driver on while idle");
    chk_lead_low: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(tx_busy) |-> !cc1_out ##1 !cc1_out) else $error("preamble not low first");
    chk_bit_edge: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (cont || lead_end) |=> $changed(line_q)) else $error("missing bit edge");
    chk_mid_edge: assert property (@(posedge ref_clk) disable iff (sys_rst)
        mid |=> (line_q != $past(line_q)) == $past(cur_bit_q)) else $error("bad mid edge");
    chk_final_edge: assert property (@(posedge ref_clk) disable iff (sys_rst)
        go_tail |=> $changed(line_q) ##1 $stable(line_q)) else $error("no closing edge");
    chk_run_bound: assert property (@(posedge ref_clk) disable iff (sys_rst)
        run_q < bmcphy_cnt_t'(2 * HALF_UI)) else $error("line held over one bit");
    chk_sel_fixed: assert property (@(posedge ref_clk) disable iff (sys_rst)
        att_q && $past(att_q) |-> $stable(sel_q)) else $error("cc line switched");
    chk_drive_side: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (cc1_oe |-> !sel_q) and (cc2_oe |-> sel_q)) else $error("wrong cc line driven");
    chk_sq_active: assert property (@(posedge ref_clk) disable iff (sys_rst)
        hit |=> rx_active) else $error("squelch missed activity");
    chk_sq_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
        w_end && !hit |=> !rx_active) else $error("squelch missed idle");
    chk_long_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
        edge_det && long_gap && !stale |=> rx_bit_valid && !rx_bit) else $error("zero lost");
endmodule

// ==== verification/bmcphy_far_end.sv ====
// bmcphy_far_end: behavioural port partner that sends one bmc packet on request
// assumes the bench resolves the shared wire and the released wire rests high on its bias
module bmcphy_far_end #(
    parameter int unsigned HALF_UI = 4
) (
    // clock
    input  wire logic        ref_clk,
    // request from the bench
    input  wire logic        send,
    input  wire logic [15:0] bits,
    input  wire logic        drop_first,
    input  wire logic        near_oe,
    // far driver
    output logic             far_out,
    output logic             far_oe,
    output logic             far_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    int i;
    int k;

    // one half bit with the line held still
    task automatic hold();
        repeat (HALF_UI) @(negedge ref_clk);
    endtask

    // released and idle at time zero
    initial begin
        far_out  = 1'b1;
        far_oe   = 1'b0;
        far_busy = 1'b0;
    end

    // lead, sixteen coded bits, closing edge, release
    always begin
        @(posedge ref_clk);
        if (send) begin
            far_busy = 1'b1;
            @(negedge ref_clk);
            for (k = 0; k < 1000 && near_oe; k++) @(negedge ref_clk);
            far_oe  = 1'b1;
            far_out = drop_first;
            hold();
            for (i = 0; i < 16; i++) begin
                far_out = ~far_out;
                hold();
                if (bits[i]) far_out = ~far_out;
                hold();
            end
            far_out = ~far_out;
            hold();
            far_oe   = 1'b0;
            far_busy = 1'b0;
        end
    end
endmodule

// ==== verification/tb_bmcphy_line_phy.sv ====
// tb_bmcphy_line_phy: random and corner packets both ways over the cc pair
// assumes the small timing parameters and a wire that idles high on its bias
module tb_bmcphy_line_phy;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned HU  = 4;
    localparam int unsigned WIN = 40;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic attached = 1'b0, orient_flip = 1'b0;
    logic tx_bit = 1'b0, tx_last = 1'b0, tx_valid = 1'b0;
    logic tx_ready, tx_busy, rx_bit, rx_bit_valid, rx_active;
    logic cc1_in, cc1_out, cc1_oe, cc2_in, cc2_out, cc2_oe;
    logic send = 1'b0, far_drop = 1'b0, far_out, far_oe, far_busy;
    logic [15:0] far_bits = 16'h0000;
    logic flip = 1'b0, sel_oe, was_oe = 1'b0, lvl, saw_act = 1'b0, bt;
    logic [7:0] pay;
    logic [31:0] seed = 32'hc1e45e54;
    int err_count = 0, n_compared = 0, run_len = 0, r, b, i;
    int runs[$], expq[$];
    logic rxq[$];

    always #20 ref_clk = ~ref_clk;

    // shared wires: near driver, far driver, else the bias level
    assign cc1_in = cc1_oe ? cc1_out : ((far_oe && !flip) ? far_out : 1'b1);
    assign cc2_in = cc2_oe ? cc2_out : ((far_oe && flip) ? far_out : 1'b1);

    bmcphy_line_phy #(.HALF_UI(HU), .EDGE_THR(6), .STALE(16), .WINDOW(WIN),
        .MIN_TRANS(3)) dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .attached(attached),
        .orient_flip(orient_flip), .tx_bit(tx_bit), .tx_last(tx_last),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_busy(tx_busy), .rx_bit(rx_bit),
        .rx_bit_valid(rx_bit_valid), .rx_active(rx_active), .cc1_in(cc1_in),
        .cc1_out(cc1_out), .cc1_oe(cc1_oe), .cc2_in(cc2_in), .cc2_out(cc2_out),
        .cc2_oe(cc2_oe));

    bmcphy_far_end #(.HALF_UI(HU)) partner (
        .ref_clk(ref_clk), .send(send), .bits(far_bits), .drop_first(far_drop),
        .near_oe(flip ? cc2_oe : cc1_oe), .far_out(far_out), .far_oe(far_oe),
        .far_busy(far_busy));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic complete_run();
        if (err_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // wait at falling edges for tx_busy, rx_active or far_busy to reach val
    task automatic wait_for(input int s, input logic val, input int lim);
        for (int k = 0; k < lim; k++) begin
            @(negedge ref_clk);
            if ((s == 0 ? tx_busy : (s == 1 ? rx_active : far_busy)) === val) return;
        end
        err_count++;
        complete_run();
    endtask

    // offer one bit until the buffer takes it
    task automatic push(input logic bv, input logic lv);
        logic ok;
        tx_bit   = bv;
        tx_last  = lv;
        tx_valid = 1'b1;
        ok = 1'b0;
        for (int k = 0; k < 100 && !ok; k++) begin
            ok = (tx_ready === 1'b1);
            @(negedge ref_clk);
        end
        if (!ok) begin
            err_count++;
            complete_run();
        end
    endtask

    // line monitor: pin choice, busy flag, run lengths, receive queue
    always @(negedge ref_clk) begin
        sel_oe = flip ? cc2_oe : cc1_oe;
        if (far_oe === 1'b1) check(sel_oe, 1'b0);
        if (!sys_rst && attached) begin
            check(flip ? cc1_oe : cc2_oe, 1'b0);
            check(tx_busy, cc1_oe | cc2_oe);
        end
        if (sel_oe === 1'b1 && !was_oe) begin
            check(cc1_out, 1'b0);
            lvl = cc1_out;
            run_len = 1;
        end else if (sel_oe === 1'b1 && cc1_out !== lvl) begin
            runs.push_back(run_len);
            lvl = cc1_out;
            run_len = 1;
        end else if (sel_oe === 1'b1) begin
            run_len++;
        end else if (was_oe) begin
            runs.push_back(run_len);
        end
        was_oe = (sel_oe === 1'b1);
        if (rx_active === 1'b1) saw_act = 1'b1;
        if (rx_bit_valid === 1'b1) rxq.push_back(rx_bit);
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(negedge ref_clk);
        check({tx_ready, tx_busy, cc1_oe, cc2_oe, rx_bit_valid, rx_active}, 6'h20);
        sys_rst = 1'b0;
        for (r = 0; r < 4; r++) begin
            flip        = r[0];
            orient_flip = flip;
            far_drop    = r[1];
            attached    = 1'b1;
            @(negedge ref_clk);
            runs.delete();
            expq.delete();
            expq.push_back(HU);
            saw_act = 1'b0;
            for (b = 0; b < 6; b++) begin
                seed = lfsr(seed);
                bt   = seed[0];
                if (b == 2) orient_flip = ~flip;
                push(bt, b == 5);
                if (bt) begin
                    expq.push_back(HU);
                    expq.push_back(HU);
                end else begin
                    expq.push_back(2 * HU);
                end
            end
            expq.push_back(HU);
            tx_valid = 1'b0;
            wait_for(0, 1'b0, 300);
            repeat (2) @(negedge ref_clk);
            check(runs.size(), expq.size());
            for (i = 0; i < expq.size() && i < runs.size(); i++) check(runs[i], expq[i]);
            check(saw_act, 1'b1);
            wait_for(1, 1'b0, 3 * WIN);
            rxq.delete();
            saw_act  = 1'b0;
            seed     = lfsr(seed);
            pay      = seed[7:0];
            far_bits = {pay, 8'haa};
            send     = 1'b1;
            @(negedge ref_clk);
            send = 1'b0;
            wait_for(2, 1'b0, 400);
            repeat (4) @(negedge ref_clk);
            check(saw_act, 1'b1);
            check(rxq.size() >= 8, 1'b1);
            for (i = 0; i < 8 && rxq.size() >= 8; i++) check(rxq[rxq.size() - 8 + i], pay[i]);
            wait_for(1, 1'b0, 3 * WIN);
            attached = 1'b0;
            @(negedge ref_clk);
        end
        flip        = 1'b0;
        orient_flip = 1'b0;
        attached    = 1'b1;
        @(negedge ref_clk);
        push(1'b1, 1'b0);
        push(1'b0, 1'b0);
        wait_for(0, 1'b1, 10);
        attached = 1'b0;
        repeat (2) @(negedge ref_clk);
        check({tx_busy, cc1_oe, cc2_oe}, 3'h0);
        for (i = 0; i < 30; i++) begin
            @(negedge ref_clk);
            check(cc1_oe | cc2_oe, 1'b0);
        end
        complete_run();
    end
endmodule
